// file: rtl/uit_pkg.sv
`default_nettype none
// ----------------------------------------
// shared constants and types for the timer
// ----------------------------------------
package uit_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] current_count_off = 8'h00;
    localparam logic [7:0] reload_count_off = 8'h04;
    localparam logic [7:0] control_status_off = 8'h08;
    localparam logic [7:0] step_status_off = 8'h0C;
    // control/status field positions in the 32-bit word
    localparam int run_pos = 0;
    localparam int transfer_now_pos = 4;
    localparam int single_step_pos = 5;
    localparam int ien_pos = 6;
    localparam int done_pos = 7;
    localparam int err_pos = 31;
    // clock and tick timing
    localparam int clock_hz = 40_000_000;
    localparam int tick_ns = 1000;
    localparam int clock_period_ns = 1_000_000_000 / clock_hz;
    localparam int tick_cycles = tick_ns / clock_period_ns;
    // compare reduction for normal counting
    localparam logic [31:0] compare_trim = 32'h0000_0003;
    // interrupt priority level of the request
    localparam logic [4:0] priority_level = 5'h18;
    // packed control byte holding the six implemented bits
    typedef struct packed {
        logic error;
        logic done;
        logic irq_enable;
        logic single_step;
        logic transfer_now;
        logic run;
    } uit_csr_type;
    // controller states
    typedef enum logic [1:0] {
        uit_idle,
        uit_clear_high,
        uit_flags
    } uit_state_type;
endpackage
`default_nettype wire

// file: rtl/uit_half_counter.sv
`default_nettype none
// ----------------------------------------
// one 16-bit counter half with terminal count
// ----------------------------------------
module uit_half_counter #(
    parameter int width = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clear,
    input wire logic advance,
    // state
    output logic [width-1:0] count,
    output logic terminal
);
    // terminal count when all ones and stepping
    assign terminal = advance && (&count);

    // clear wins over advance so a reload cannot be missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (advance) begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/uit_interval_timer.sv
// The register addresses and the APB slave port were chosen for this implementation.
`default_nettype none
module uit_interval_timer #(
    parameter int tick_div = uit_pkg::tick_cycles
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer outputs
    output logic timer_irq_request,
    output logic [4:0] irq_priority_level,
    output logic count_go_output
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    uit_pkg::uit_csr_type csr; // packed control byte
    uit_pkg::uit_state_type state;
    logic [31:0] reload_positive; // complemented reload value
    logic [31:0] reload_negative; // last value software wrote
    logic [31:0] compare; // alarm value
    logic reload_changed; // reload written since compare load
    logic stepped_compare; // compare currently unreduced
    logic match_latch; // match event seen
    logic reset_pulse; // one-cycle low-half clear
    logic [31:0] capture; // snapshot for reads
    logic [15:0] low_count;
    logic [15:0] high_count;
    logic low_tc;
    logic [$clog2(tick_div+1)-1:0] div_count;
    logic tick;
    logic step_req;
    logic gate_low;
    logic wr_access;
    logic rd_access;
    logic wr_csr;
    logic wr_reload;
    logic clear_high;
    logic xfer_now; // control write carrying transfer-now

    // decode a word offset against the bus address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // zero wait states: every access completes in its access phase
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign wr_csr = wr_access && hit(paddr, uit_pkg::control_status_off);
    assign wr_reload = wr_access && hit(paddr, uit_pkg::reload_count_off);
    // transfer-now acts in the write cycle itself, so a load and a
    // count edge can never split across two cycles
    assign xfer_now = wr_csr && pwdata[uit_pkg::transfer_now_pos];
    // unmapped addresses answer with an error
    // writes there change nothing, reads there return zero
    assign pslverr = psel && penable &&
        !(hit(paddr, uit_pkg::current_count_off) ||
          hit(paddr, uit_pkg::reload_count_off) ||
          hit(paddr, uit_pkg::control_status_off) ||
          hit(paddr, uit_pkg::step_status_off));

    // ----------------------------------------
    // tick divider
    // ----------------------------------------
    // microsecond tick
    // the 40 MHz clock stands in for the divided processor clock
    // limitation: the divider is not restarted by the run bit, so the
    // first tick after a start lands anywhere within one microsecond
    assign tick = (div_count == tick_div[$bits(div_count)-1:0] - 1'b1);

    // divider free-runs so the tick phase is fixed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= '0;
        end else if (tick) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 1'b1;
        end
    end

    // ----------------------------------------
    // counter halves
    // ----------------------------------------
    // run starts counting
    assign count_go_output = csr.run;
    // the reset pulse closes the gate for one cycle, dropping that tick
    assign gate_low = count_go_output && !reset_pulse;
    // single step
    // a step while running is ignored: the free count owns the halves
    assign step_req = wr_csr && !csr.run && pwdata[uit_pkg::single_step_pos];
    assign clear_high = (state == uit_pkg::uit_clear_high);

    // pulse clears low half
    // transfer-now zeroes both halves so the new interval starts clean
    uit_half_counter #(.width(16)) low_half (
        .pclk(pclk),
        .presetn(presetn),
        .clear(reset_pulse || xfer_now),
        .advance((gate_low && tick) || step_req),
        .count(low_count),
        .terminal(low_tc)
    );

    // high half on carry
    // the high half sees no reset pulse; the controller clears it
    uit_half_counter #(.width(16)) high_half (
        .pclk(pclk),
        .presetn(presetn),
        .clear(clear_high || xfer_now),
        .advance(low_tc),
        .count(high_count),
        .terminal()
    );

    // ----------------------------------------
    // reload and compare
    // ----------------------------------------
    // the ones' complement of the written value is kept, so a reload
    // of minus n leaves n-1, the last count of an n-state interval
    // complement on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_positive <= '0;
            reload_negative <= '0;
        end else if (wr_reload) begin
            reload_positive <= ~pwdata;
            reload_negative <= pwdata;
        end
    end

    // minus three trim
    // trade-off: the trim is sized for a slow external clear; here the
    // low half clears one cycle after the match, so a running interval
    // comes out a little shorter than the written period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare <= '0;
            reload_changed <= 1'b0;
            stepped_compare <= 1'b0;
        end else if (xfer_now) begin
            if (pwdata[uit_pkg::run_pos]) begin
                compare <= reload_positive - uit_pkg::compare_trim;
            end else begin
                compare <= reload_positive;
            end
            stepped_compare <= !pwdata[uit_pkg::run_pos];
            reload_changed <= 1'b0;
        end else if (state == uit_pkg::uit_clear_high && reload_changed) begin
            compare <= reload_positive - uit_pkg::compare_trim;
            stepped_compare <= 1'b0;
            // a reload written in this very cycle is still pending
            reload_changed <= wr_reload;
        end else if (wr_reload) begin
            reload_changed <= 1'b1;
        end
    end

    // ----------------------------------------
    // match detect
    // ----------------------------------------
    // match latch and pulse
    // a compare of zero never matches, so an unloaded timer stays quiet
    // the latch blocks a second match until the flags are updated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_latch <= 1'b0;
            reset_pulse <= 1'b0;
        end else begin
            reset_pulse <= 1'b0;
            if (!match_latch && (csr.run || stepped_compare) &&
                {high_count, low_count} == compare &&
                compare != '0) begin
                match_latch <= 1'b1;
                reset_pulse <= 1'b1;
            end else if (state == uit_pkg::uit_flags) begin
                match_latch <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // controller
    // ----------------------------------------
    // walks a match through high clear then flag update
    // one state per cleanup step, so a read in between may see a
    // cleared low half above a high half not yet zeroed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= uit_pkg::uit_idle;
        end else begin
            case (state)
                uit_pkg::uit_idle: begin
                    // wait for a latched match
                    if (match_latch) begin
                        state <= uit_pkg::uit_clear_high;
                    end
                end
                uit_pkg::uit_clear_high: begin
                    // high half is zeroed while here
                    state <= uit_pkg::uit_flags;
                end
                uit_pkg::uit_flags: begin
                    state <= uit_pkg::uit_idle;
                end
                default: begin
                    state <= uit_pkg::uit_idle;
                end
            endcase
        end
    end

    // ----------------------------------------
    // control/status byte
    // ----------------------------------------
    // packed byte
    // other bits ignored
    // pulse bits only fill the byte; they never hold a one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr <= '0;
        end else begin
            if (wr_csr) begin
                csr.run <= pwdata[uit_pkg::run_pos];
                csr.irq_enable <= pwdata[uit_pkg::ien_pos];
                // transfer and step act at once and read as zero
                csr.transfer_now <= 1'b0;
                csr.single_step <= 1'b0;
            end
            if (wr_csr && (pwdata[uit_pkg::done_pos] ||
                           !pwdata[uit_pkg::ien_pos])) begin
                csr.done <= 1'b0;
            end
            if (wr_csr && pwdata[uit_pkg::err_pos]) begin
                csr.error <= 1'b0;
            end
            // done on interval end; set wins over clear
            if (state == uit_pkg::uit_flags) begin
                if (csr.done) begin
                    csr.error <= 1'b1;
                end else begin
                    csr.done <= 1'b1;
                end
            end
        end
    end

    // enabling with done pending
    // the request follows the flags, so both clear paths drop it too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_request <= 1'b0;
        end else begin
            timer_irq_request <= csr.done && csr.irq_enable;
        end
    end
    // fixed level; the host arbitrates between its sources
    assign irq_priority_level = uit_pkg::priority_level;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // capture without disturbing
    // capture zeroed at reset
    // capture at the setup phase: a current count read returns the count as it stood
    // when the transfer began, which may be a pair caught mid-cleanup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture <= '0;
        end else if (psel && !penable && !pwrite) begin
            capture <= {high_count, low_count};
        end
    end

    // negative form on read
    // unmapped offsets and writes leave the read bus at zero
    always_comb begin
        prdata = '0;
        if (rd_access) begin
            if (hit(paddr, uit_pkg::current_count_off)) begin
                prdata = capture + reload_negative;
            end else if (hit(paddr, uit_pkg::reload_count_off)) begin
                prdata = reload_negative;
            end else if (hit(paddr, uit_pkg::control_status_off)) begin
                prdata[uit_pkg::run_pos] = csr.run;
                prdata[uit_pkg::ien_pos] = csr.irq_enable;
                prdata[uit_pkg::done_pos] = csr.done;
                prdata[uit_pkg::err_pos] = csr.error;
            end else if (hit(paddr, uit_pkg::step_status_off)) begin
                prdata = {high_count, low_count};
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/uit_interval_timer_checker.sv
`default_nettype none
// -------------------------------------
// port checks of the interval timer
// -------------------------------------
module uit_interval_timer_checker #(
    parameter int tick_div = 40
) (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // timer outputs
    input wire logic timer_irq_request,
    input wire logic [4:0] irq_priority_level,
    input wire logic count_go_output
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase and its kind
    wire logic acc = psel && penable;
    wire logic is_csr = paddr == uit_pkg::control_status_off;
    wire logic csr_wr = acc && pwrite && is_csr;
    wire logic csr_rd = acc && !pwrite && is_csr;
    wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
    chk_zero_wait: assert property (acc |-> pready)
        else $error("access without ready");
    chk_unmapped_err: assert property (acc |-> pslverr == !mapped)
        else $error("error response wrong");
    chk_idle_rdata: assert property (!acc |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    chk_level_const: assert property (
        irq_priority_level == uit_pkg::priority_level)
        else $error("priority level wrong");
    chk_go_follows: assert property (
        csr_wr |=> count_go_output == $past(pwdata[uit_pkg::run_pos]))
        else $error("count go not following run");
    chk_go_cause: assert property (
        $changed(count_go_output) |-> $past(csr_wr))
        else $error("count go changed alone");
    // ien low must drop the request and keep it down a while
    chk_irq_disable: assert property (
        csr_wr && !pwdata[uit_pkg::ien_pos] |-> ##2 !timer_irq_request [*3])
        else $error("request left after disable");
    chk_csr_unused: assert property (
        csr_rd |-> prdata[30:8] == 23'h0 && prdata[5:1] == 5'h0)
        else $error("unused status bits set");
    cover property ($rose(timer_irq_request));
    cover property (acc && pslverr);
    cover property (csr_wr && pwdata[uit_pkg::single_step_pos]);
endmodule
bind uit_interval_timer uit_interval_timer_checker #(.tick_div(tick_div))
    i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .timer_irq_request(timer_irq_request),
    .irq_priority_level(irq_priority_level),
    .count_go_output(count_go_output));
`default_nettype wire

// file: testbench/uit_host_model.sv
`default_nettype none
// -------------------------------------
// host issuing register accesses on apb
// -------------------------------------
module uit_host_model (
    // clock
    input wire logic pclk,
    // request
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [31:0] pwdata,
    // answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // one transfer: setup, then access held until ready is seen
    task automatic access(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look like still valid
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// file: testbench/uit_interval_timer_tb.sv
`default_nettype none
module uit_interval_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------
    // clock, reset and wiring
    // -------------------------------------
    localparam int tick_div = 4; // short tick keeps the run brief
    localparam logic [7:0] cur = uit_pkg::current_count_off;
    localparam logic [7:0] rld = uit_pkg::reload_count_off;
    localparam logic [7:0] csr = uit_pkg::control_status_off;
    localparam logic [7:0] raw = uit_pkg::step_status_off;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, go;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] level;
    logic er;
    int fail_count = 0;
    int samples_checked = 0;
    always #12.5 pclk = ~pclk;
    uit_interval_timer #(.tick_div(tick_div)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_irq_request(irq),
        .irq_priority_level(level), .count_go_output(go));
    uit_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // -------------------------------------
    // shared tasks
    // -------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] x,
        input string m);
        samples_checked++;
        if (s !== x) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, s, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.access(1'b1, a, d, rd, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
        input string m);
        i_host.access(1'b0, a, 32'h0000_0000, rd, er);
        check(rd, x, m);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // -------------------------------------
    // scenarios
    // -------------------------------------
    task automatic t_regs();
        rdc(csr, 32'h0000_0000, "csr reset");
        rdc(raw, 32'h0000_0000, "count reset");
        check({27'h0, level}, 32'h0000_0018, "level");
        wr(rld, 32'hFFFF_FFF6);
        rdc(rld, 32'hFFFF_FFF6, "reload back");
        wr(csr, 32'h7FFF_FF0E);
        rdc(csr, 32'h0000_0000, "unused bits");
        i_host.access(1'b0, 8'h10, 32'h0000_0000, rd, er);
        check({31'h0, er}, 32'h0000_0001, "unmapped");
        $display("test regs done");
    endtask
    // stopped counter: transfer, then nine single steps up to the match;
    // a reload of minus ten complements to a compare of nine
    task automatic t_step();
        wr(csr, 32'h0000_0050);
        rdc(raw, 32'h0000_0000, "after transfer");
        for (int k = 1; k <= 8; k++) begin
            wr(csr, 32'h0000_0060);
            rdc(raw, 32'(k), "step");
            rdc(cur, 32'(k - 10), "negative count");
        end
        check({31'h0, irq}, 32'h0000_0000, "early irq");
        wr(csr, 32'h0000_0060);
        repeat (6) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0001, "irq on match");
        rdc(csr, 32'h0000_00C0, "done");
        rdc(raw, 32'h0000_0000, "halves cleared");
        wr(csr, 32'h0000_00C0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000, "irq cleared");
        rdc(csr, 32'h0000_0040, "done cleared");
        wr(csr, 32'h0000_0000);
        $display("test step done");
    endtask
    // running counter: interval end, late enable, overrun
    task automatic t_run();
        wr(rld, 32'hFFFF_FFEC);
        wr(csr, 32'h0000_0011);
        @(posedge pclk);
        check({31'h0, go}, 32'h0000_0001, "count go");
        repeat (100) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000, "masked irq");
        rdc(csr, 32'h0000_0081, "done running");
        wr(csr, 32'h0000_0041);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0001, "late enable");
        repeat (50) @(posedge pclk);
        rdc(csr, 32'h8000_00C1, "overrun");
        wr(csr, 32'h8000_0080);
        rdc(csr, 32'h0000_0000, "flags clear");
        check({31'h0, go}, 32'h0000_0000, "stopped");
        $display("test run done");
    endtask
    // -------------------------------------
    // sequence and watchdog
    // -------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_step();
        t_run();
        end_sim();
    end
    // the whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
